// ===== pkg/touch_pkg.sv
/*
 * Shared constants for the resistive touch readout: register offsets,
 * field positions, reset values, plate bias codes, channel ids, timing.
 * Assumes a 25 MHz mclk and a word-aligned plain register port.
 */
package touch_pkg;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL0   = 8'h00; // mode, settle delay
    localparam logic [7:0] OFF_CTRL1   = 8'h04; // pull resistor, aux use
    localparam logic [7:0] OFF_CHANMSK = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0c;
    localparam logic [7:0] OFF_CMD     = 8'h10;
    localparam logic [7:0] OFF_RATE    = 8'h14;
    localparam logic [7:0] OFF_RES_LO  = 8'h20; // first result word
    localparam logic [7:0] OFF_RES_HI  = 8'h30; // last result word

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTRL0_MODE_LSB  = 0;  // two bits
    localparam int CTRL0_DLY_LSB   = 4;  // four bits
    localparam int CTRL1_PULL_LSB  = 0;  // two bits
    localparam int CTRL1_AUXTRG    = 2;
    localparam int CTRL1_RISE      = 3;
    localparam int CTRL1_FALL      = 4;
    localparam int CMD_START       = 0;
    localparam int STAT_PEN        = 0;
    localparam int STAT_DATA       = 1;
    localparam int STAT_BUSY       = 2;
    localparam int STAT_LEVEL      = 3;
    localparam int STAT_ADDR       = 4;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL0_RST   = 8'h00;
    localparam logic [4:0] CTRL1_RST   = 5'h00;
    localparam logic [4:0] CHANMSK_RST = 5'h03; // X and Y
    localparam logic [7:0] RATE_RST    = 8'h10;

    // Operating modes
    localparam logic [1:0] MODE_MANUAL = 2'h0;
    localparam logic [1:0] MODE_AUTO   = 2'h1;
    localparam logic [1:0] MODE_PEN_INTERRUPT_MODE = 2'h2;
    localparam logic [1:0] MODE_PEN_TRIGGER_MODE = 2'h3;

    // Channel ids, also the sequence order
    localparam logic [2:0] CH_X    = 3'h0;
    localparam logic [2:0] CH_Y    = 3'h1;
    localparam logic [2:0] CH_Z1   = 3'h2;
    localparam logic [2:0] CH_Z2   = 3'h3;
    localparam logic [2:0] CH_AUX  = 3'h4;
    localparam logic [2:0] CH_END  = 3'h5;
    localparam logic [15:0] INVALID_WORD = 16'hffff;

    // Plate bias codes driven to the analog front end
    localparam logic [2:0] BIAS_OFF = 3'h0;
    localparam logic [2:0] BIAS_PEN = 3'h6; // X+ to Y- through pull resistor

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int US_NS         = 1000;
    localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] US_LAST = 5'(US_CYCLES - 1);
    localparam int RATE_SHIFT    = 6; // auto interval = rate * 64 us

    // Sequencer states, Gray from IDLE through SELECT and SETTLE to SAMPLE
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SELECT = 3'b001,
        ST_SETTLE = 3'b011,
        ST_SAMPLE = 3'b010,
        ST_WAIT   = 3'b110
    } seq_state_t;

endpackage

// ===== verilog/sync2.sv
/*
 * Two-flop synchroniser for pins and analog comparator levels.
 * Assumes the inputs are quasi-static levels; only the second stage
 * is visible outside.
 */
`timescale 1ns/1ns
`default_nettype none

module sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // Two stages, first read only by the second
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ===== verilog/chan_store.sv
/*
 * Result store: eight 16-bit words, one write port, one read port
 * whose data come out of a register one cycle after the address.
 * Assumes a single writer, the conversion sequencer.
 */
`timescale 1ns/1ns
`default_nettype none

module chan_store (
    // Clock
    input  wire logic        mclk,
    // Write port
    input  wire logic        we,
    input  wire logic [2:0]  waddr,
    input  wire logic [15:0] wdata,
    // Read port
    input  wire logic [2:0]  raddr,
    output logic      [15:0] rdata
);

    logic [15:0] mem [8];

    // Write and registered read
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

`default_nettype wire

// ===== verilog/touch_readout.sv
/*
 * Control logic of a four-wire resistive touch panel readout: plate bias
 * sequencing, settle timing, pen detection, aux trigger, result words,
 * status flags and the open-drain host interrupt.
 * Assumes a converter on mclk (start pulse, done pulse, 12-bit code)
 * and a register master on the plain port; the serial host link that
 * uses the address select bit lives outside.
 */
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module touch_readout (
    // Clock and hardware reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // Analog front end
    output logic      [2:0]  plate_bias,
    output logic      [1:0]  pen_pull_resistor,
    input  wire logic        pen_cmp,
    output logic             adc_start,
    input  wire logic        adc_done,
    input  wire logic [11:0] adc_code,
    // Pins
    input  wire logic        aux_pin,
    input  wire logic        addr_select_pin,
    output logic             addr_lsb,
    output logic             host_irq_n_out,
    output logic             host_irq_n_oe
);

    // ---------------------------------------------------------------
    // State record
    // ---------------------------------------------------------------
    typedef struct packed {
        touch_pkg::seq_state_t st;
        logic [7:0]  ctrl0;
        logic [4:0]  ctrl1;
        logic [4:0]  chmask;
        logic [7:0]  rate;
        logic        pen_flag;
        logic        data_flag;
        logic        irq;
        logic        pen_prev;
        logic        aux_prev;
        logic        pen_ok;
        logic [2:0]  ch;
        logic [15:0] dly;
        logic [4:0]  tick_cnt;
        logic        tick;
        logic        adc_start;
        logic [2:0]  bias;
        logic        rsel_mem;
        logic [15:0] rdata;
        logic        addr_lsb;
        logic        mem_we;
        logic [2:0]  mem_wa;
        logic [15:0] mem_wd;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic        pen_lvl;
    logic        aux_lvl;
    logic        asel_lvl;
    logic [15:0] mem_rd;
    logic [2:0]  mem_ra;
    logic [1:0]  mode;
    logic        det_active;
    logic        det_evt;
    logic        aux_evt;
    logic        stat_rd;
    logic        seq_start;

    // Result word: id in bits 14:12, code below
    function automatic logic [15:0] chan_word(input logic [2:0] id,
                                              input logic [11:0] code);
        chan_word = {1'b0, id, code};
    endfunction

    // Channel enabled for conversion
    function automatic logic chan_on(input logic [4:0] msk,
                                     input logic       auxtrg,
                                     input logic [2:0] id);
        if (id == touch_pkg::CH_AUX) begin
            chan_on = msk[4] && !auxtrg;
        end else begin
            chan_on = msk[id];
        end
    endfunction

    // ---------------------------------------------------------------
    // Synchronisers and result store
    // ---------------------------------------------------------------
    // comparator, aux pin and address select pin synchronised
    sync2 #(.W(3)) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in ({pen_cmp, aux_pin, addr_select_pin}),
        .sync_out ({pen_lvl, aux_lvl, asel_lvl})
    );

    chan_store u_store (
        .mclk  (mclk),
        .we    (s_q.mem_we),
        .waddr (s_q.mem_wa),
        .wdata (s_q.mem_wd),
        .raddr (mem_ra),
        .rdata (mem_rd)
    );

    // Result words live in the store; its register stands in for ours
    assign mem_ra = 3'((addr - touch_pkg::OFF_RES_LO) >> 2);

    // ---------------------------------------------------------------
    // Event decode
    // ---------------------------------------------------------------
    assign mode       = s_q.ctrl0[touch_pkg::CTRL0_MODE_LSB +: 2];
    // Comparator is only meaningful while the detect bias is applied
    assign det_active = (s_q.bias == touch_pkg::BIAS_PEN);
    assign det_evt    = det_active && pen_lvl && !s_q.pen_prev;
    assign aux_evt    = s_q.ctrl1[touch_pkg::CTRL1_AUXTRG] &&
                        ((s_q.ctrl1[touch_pkg::CTRL1_RISE] && aux_lvl && !s_q.aux_prev) ||
                         (s_q.ctrl1[touch_pkg::CTRL1_FALL] && !aux_lvl && s_q.aux_prev));
    assign stat_rd    = rd && (addr == touch_pkg::OFF_STATUS);
    assign seq_start  = (wr && addr == touch_pkg::OFF_CMD && wdata[touch_pkg::CMD_START]) ||
                        (mode == touch_pkg::MODE_PEN_TRIGGER_MODE && det_evt) ||
                        (mode == touch_pkg::MODE_AUTO) || aux_evt;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d           = s_q;
        s_d.adc_start = 1'b0;
        s_d.mem_we    = 1'b0;
        s_d.rsel_mem  = 1'b0;
        s_d.aux_prev  = aux_lvl;
        s_d.addr_lsb  = asel_lvl;
        // Detect edge needs a release first, so a held pen fires once
        s_d.pen_prev  = det_active ? pen_lvl : 1'b1;

        // Microsecond enable divider
        s_d.tick     = (s_q.tick_cnt == touch_pkg::US_LAST);
        s_d.tick_cnt = s_d.tick ? 5'h00 : s_q.tick_cnt + 5'h01;

        // Register writes
        if (wr) begin
            case (addr)
                touch_pkg::OFF_CTRL0:   s_d.ctrl0  = wdata[7:0];
                touch_pkg::OFF_CTRL1:   s_d.ctrl1  = wdata[4:0];
                touch_pkg::OFF_CHANMSK: s_d.chmask = wdata[4:0];
                touch_pkg::OFF_RATE:    s_d.rate   = wdata[7:0];
                default:                s_d.rate   = s_q.rate;
            endcase
        end

        // Register reads, answered in the next cycle
        s_d.rdata = 16'h0000;
        if (rd) begin
            case (addr)
                touch_pkg::OFF_CTRL0:   s_d.rdata = {8'h00, s_q.ctrl0};
                touch_pkg::OFF_CTRL1:   s_d.rdata = {11'h000, s_q.ctrl1};
                touch_pkg::OFF_CHANMSK: s_d.rdata = {11'h000, s_q.chmask};
                touch_pkg::OFF_RATE:    s_d.rdata = {8'h00, s_q.rate};
                touch_pkg::OFF_STATUS: begin
                    s_d.rdata[touch_pkg::STAT_PEN]   = s_q.pen_flag;
                    s_d.rdata[touch_pkg::STAT_DATA]  = s_q.data_flag;
                    s_d.rdata[touch_pkg::STAT_BUSY]  = (s_q.st != touch_pkg::ST_IDLE);
                    s_d.rdata[touch_pkg::STAT_LEVEL] = pen_lvl;
                    s_d.rdata[touch_pkg::STAT_ADDR]  = s_q.addr_lsb;
                end
                default: begin
                    s_d.rsel_mem = (addr >= touch_pkg::OFF_RES_LO) &&
                                   (addr <= touch_pkg::OFF_RES_HI) && (addr[1:0] == 2'h0);
                end
            endcase
        end

        if (stat_rd) begin
            s_d.pen_flag  = 1'b0;
            s_d.data_flag = 1'b0;
        end
        if (det_evt) begin
            s_d.pen_flag = 1'b1;
        end

        // Conversion sequencer
        case (s_q.st)
            touch_pkg::ST_IDLE, touch_pkg::ST_WAIT: begin
                s_d.bias = touch_pkg::BIAS_PEN;
                if (s_q.st == touch_pkg::ST_IDLE ? seq_start :
                    (mode != touch_pkg::MODE_AUTO || (s_q.tick && s_q.dly == 16'h0000))) begin
                    s_d.st     = touch_pkg::ST_SELECT;
                    s_d.ch     = touch_pkg::CH_X;
                    s_d.pen_ok = pen_lvl;
                    if (s_q.st == touch_pkg::ST_WAIT && mode != touch_pkg::MODE_AUTO) begin
                        s_d.st = touch_pkg::ST_IDLE;
                    end
                end else if (s_q.tick && s_q.dly != 16'h0000) begin
                    s_d.dly = s_q.dly - 16'h0001;
                end
            end
            touch_pkg::ST_SELECT: begin
                s_d.bias = touch_pkg::BIAS_OFF;
                if (s_q.ch == touch_pkg::CH_END) begin
                    s_d.data_flag = 1'b1;
                    s_d.st        = touch_pkg::ST_IDLE;
                    if (mode == touch_pkg::MODE_AUTO) begin
                        s_d.st  = touch_pkg::ST_WAIT;
                        s_d.dly = 16'({s_q.rate, 6'h00});
                    end
                end else if (chan_on(s_q.chmask, s_q.ctrl1[touch_pkg::CTRL1_AUXTRG], s_q.ch)) begin
                    s_d.bias = s_q.ch + 3'h1;
                    // settle count, one extra tick rounds up
                    s_d.dly  = 16'h0001 << s_q.ctrl0[touch_pkg::CTRL0_DLY_LSB +: 4];
                    s_d.st   = touch_pkg::ST_SETTLE;
                end else begin
                    s_d.ch = s_q.ch + 3'h1;
                end
            end
            touch_pkg::ST_SETTLE: begin
                if (s_q.tick) begin
                    if (s_q.dly == 16'h0000) begin
                        s_d.adc_start = 1'b1;
                        s_d.st        = touch_pkg::ST_SAMPLE;
                    end else begin
                        s_d.dly = s_q.dly - 16'h0001;
                    end
                end
            end
            touch_pkg::ST_SAMPLE: begin
                if (adc_done) begin
                    s_d.mem_we = 1'b1;
                    s_d.mem_wa = s_q.ch;
                    s_d.mem_wd = chan_word(s_q.ch, adc_code);
                    if (!s_q.pen_ok && s_q.ch != touch_pkg::CH_AUX) begin
                        s_d.mem_wd = touch_pkg::INVALID_WORD;
                    end
                    s_d.ch = s_q.ch + 3'h1;
                    s_d.st = touch_pkg::ST_SELECT;
                end
            end
            default: s_d.st = touch_pkg::ST_IDLE;
        endcase

        // pen interrupt only in pen-detect mode
        s_d.irq = (s_d.pen_flag && mode == touch_pkg::MODE_PEN_INTERRUPT_MODE) || s_d.data_flag;
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    // hardware reset clears, then loads the register reset values
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q        <= '0;
            s_q.ctrl0  <= touch_pkg::CTRL0_RST;
            s_q.ctrl1  <= touch_pkg::CTRL1_RST;
            s_q.chmask <= touch_pkg::CHANMSK_RST;
            s_q.rate   <= touch_pkg::RATE_RST;
            s_q.st     <= touch_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign rdata             = s_q.rsel_mem ? mem_rd : s_q.rdata;
    assign plate_bias        = s_q.bias;
    assign pen_pull_resistor = s_q.ctrl1[touch_pkg::CTRL1_PULL_LSB +: 2];
    assign adc_start         = s_q.adc_start;
    assign addr_lsb          = s_q.addr_lsb;
    assign host_irq_n_out    = 1'b0;
    assign host_irq_n_oe     = s_q.irq;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence seq_pen_hit;
        det_evt && mode == touch_pkg::MODE_PEN_INTERRUPT_MODE;
    endsequence
    sequence seq_settle_done;
        s_q.st == touch_pkg::ST_SETTLE && s_q.tick && s_q.dly == 16'h0000;
    endsequence

    AST_PEN_FLAG: assert property (det_evt |=> s_q.pen_flag)
        else $error("pen flag not set");
    AST_PEN_IRQ: assert property (seq_pen_hit |=> host_irq_n_oe ##0 !host_irq_n_out)
        else $error("pen interrupt not driven low");
    AST_STAT_CLR: assert property (stat_rd && !det_evt |=> !s_q.pen_flag)
        else $error("status read did not clear pen flag");
    AST_TRG_START: assert property (s_q.st == touch_pkg::ST_IDLE && det_evt &&
        mode == touch_pkg::MODE_PEN_TRIGGER_MODE |=> s_q.st == touch_pkg::ST_SELECT)
        else $error("pen trigger did not start");
    AST_AUX_START: assert property (s_q.st == touch_pkg::ST_IDLE && aux_evt
        |=> s_q.st == touch_pkg::ST_SELECT)
        else $error("aux edge did not start");
    AST_SETTLE: assert property ($rose(adc_start) |-> $past(s_q.st) == touch_pkg::ST_SETTLE)
        else $error("sample without settle");
    AST_START_AFTER: assert property (seq_settle_done |=> adc_start ##1 !adc_start)
        else $error("start pulse wrong");
    AST_INVALID: assert property (s_q.mem_we && !s_q.pen_ok && s_q.mem_wa != touch_pkg::CH_AUX
        |-> s_q.mem_wd == touch_pkg::INVALID_WORD)
        else $error("invalid marker missing");
    AST_WORD_ID: assert property (s_q.mem_we && s_q.pen_ok
        |-> s_q.mem_wd[14:12] == s_q.mem_wa)
        else $error("channel id mismatch");
    AST_ADDR_SEL: assert property (asel_lvl |=> addr_lsb)
        else $error("address select not followed");
    AST_DATA_IRQ: assert property (s_q.st == touch_pkg::ST_SELECT && s_q.ch == touch_pkg::CH_END
        |=> s_q.data_flag && host_irq_n_oe)
        else $error("data interrupt missing");

endmodule

`default_nettype wire

// ===== testbench/conv_model.sv
/* Converter stand-in for the touch readout.
   Assumes one-cycle start pulses on mclk; code carries the bias seen. */
`timescale 1ns/1ns
`default_nettype none
module conv_model #(
    parameter int LAT = 6
) (
    // Clock
    input  wire logic        mclk,
    // Converter link
    input  wire logic        adc_start,
    input  wire logic [2:0]  plate_bias,
    output logic             adc_done,
    output logic      [11:0] adc_code
);
    int         cnt = 0;
    logic [2:0] bias_q = 3'h0;
    // Code tags the bias, so a wrong setup shows in the result
    always @(posedge mclk) begin
        adc_done <= 1'b0;
        adc_code <= {3'h7, 9'h1aa}; // Filler, never a real bias tag
        if (adc_start) begin
            cnt <= LAT;
            bias_q <= plate_bias;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                adc_done <= 1'b1;
                adc_code <= {bias_q, 9'h055};
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
/* Self-checking bench for touch_readout with a converter stand-in.
   Assumes the register map and timing of the design package. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        pen_cmp = 1'b0;
    logic        aux_pin = 1'b0;
    logic        addr_select_pin = 1'b0;
    logic [15:0] rdata, v;
    logic [11:0] adc_code;
    logic [2:0]  plate_bias;
    logic [1:0]  pen_pull_resistor;
    logic        adc_start, adc_done, addr_lsb, host_irq_n_out, host_irq_n_oe;
    wire logic   irq = host_irq_n_oe ? host_irq_n_out : 1'b1; // Pull-up
    int          failures = 0;
    int          num_checks = 0;

    always #20 mclk = ~mclk;

    touch_readout dut (.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
        .plate_bias, .pen_pull_resistor, .pen_cmp, .adc_start, .adc_done,
        .adc_code, .aux_pin, .addr_select_pin, .addr_lsb, .host_irq_n_out,
        .host_irq_n_oe);
    conv_model cm (.mclk, .adc_start, .plate_bias, .adc_done, .adc_code);

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Bus cycles; the trailing edge keeps strobes from being set twice
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
        @(posedge mclk);
    endtask
    // Bounded wait: 0 for interrupt low, 1 for a converter start
    task automatic wait_ev(input int k);
        for (int i = 0; i < 3000; i++) begin
            @(posedge mclk);
            #1;
            if (k == 0 ? irq === 1'b0 : adc_start === 1'b1) begin
                @(posedge mclk);
                return;
            end
        end
        failures++;
        $display("BAD wait%0d expected 1 seen 0", k);
        close_out();
    endtask

    task automatic t_idle;
        chk("bias", 16'(plate_bias), 16'h0006); // detect setup
        chk("irq", 16'(irq), 16'h0001); // released line
        @(posedge mclk);
        addr_select_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("addr_lsb", 16'(addr_lsb), 16'h0001); // pin level
        wr_reg(touch_pkg::OFF_CTRL1, 16'h0001);
        chk("pull", 16'(pen_pull_resistor), 16'h0001); // largest pull
        rd_reg(touch_pkg::OFF_STATUS);
        chk("status", v, 16'h0010); // address bit
        $display("idle done");
    endtask
    task automatic t_pen_interrupt_mode;
        wr_reg(touch_pkg::OFF_CTRL0, 16'h0002);
        pen_cmp <= 1'b1;
        wait_ev(0); // irq pulled low
        rd_reg(touch_pkg::OFF_STATUS);
        chk("pen_flag", v & 16'h0001, 16'h0001); // flag set
        chk("irq_rel", 16'(irq), 16'h0001); // read releases
        $display("pen_interrupt_mode done");
    endtask
    // Manual sequence; no pen means invalid words except aux
    task automatic t_conv(input logic pen, input logic [4:0] m, input logic [3:0] d);
        logic [15:0] e;
        pen_cmp <= pen;
        wr_reg(touch_pkg::OFF_CTRL0, {8'h00, d, 4'h0}); // settle delay d, manual mode
        wr_reg(touch_pkg::OFF_CHANMSK, {11'h000, m});
        wr_reg(touch_pkg::OFF_CMD, 16'h0001);
        wait_ev(0); // data irq
        rd_reg(touch_pkg::OFF_STATUS);
        chk("data_flag", v & 16'h0002, 16'h0002); // data flag
        for (int c = 0; c < 5; c++) begin
            if (m[c]) begin
                e = (pen || c == 4) ? {1'b0, 3'(c), 3'(c + 1), 9'h055} : 16'hffff;
                rd_reg(8'h20 + 8'(4 * c));
                chk("word", v, e);
            end
        end
        $display("conv done");
    endtask
    // Automatic mode: runs at once, then waits rate * 64 us between runs
    task automatic t_auto;
        wr_reg(touch_pkg::OFF_RATE, 16'h0001);
        wr_reg(touch_pkg::OFF_CTRL0, 16'h0001);
        wait_ev(0); // first run at once
        rd_reg(touch_pkg::OFF_STATUS);
        chk("auto_data", v & 16'h0002, 16'h0002); // data flag
        repeat (1000) @(posedge mclk);
        #1 chk("auto_gap", 16'(irq), 16'h0001); // timer still running
        wait_ev(0); // next run on expiry
        wr_reg(touch_pkg::OFF_CTRL0, 16'h0000);
        rd_reg(touch_pkg::OFF_STATUS);
        chk("auto_again", v & 16'h0002, 16'h0002); // second run
        $display("auto done");
    endtask
    task automatic t_pen_trigger_mode;
        pen_cmp <= 1'b0;
        wr_reg(touch_pkg::OFF_CHANMSK, 16'h0003);
        wr_reg(touch_pkg::OFF_CTRL0, 16'h0003);
        pen_cmp <= 1'b1;
        wait_ev(1); // pen starts
        wait_ev(0);
        rd_reg(touch_pkg::OFF_RES_LO);
        chk("trg_word", v, 16'h0255); // X result
        rd_reg(touch_pkg::OFF_STATUS);
        chk("trg_data", v & 16'h0002, 16'h0002); // data flag
        $display("pen_trigger_mode done");
    endtask
    task automatic t_aux;
        wr_reg(touch_pkg::OFF_CTRL0, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            pen_cmp <= 1'(i);
            wr_reg(touch_pkg::OFF_CTRL1, i ? 16'h0015 : 16'h000d);
            aux_pin <= ~aux_pin;
            wait_ev(0); // edge starts
            rd_reg(touch_pkg::OFF_STATUS);
            rd_reg(touch_pkg::OFF_RES_LO);
            chk("aux_word", v, i ? 16'h0255 : 16'hffff); // trigger use
        end
        $display("aux done");
    endtask
    task automatic t_reset;
        pen_cmp <= 1'b0;
        wr_reg(touch_pkg::OFF_CTRL0, 16'h0002);
        pen_cmp <= 1'b1;
        wait_ev(0);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1 chk("rst_irq", 16'(irq), 16'h0001); // state cleared
        @(posedge mclk);
        rd_reg(touch_pkg::OFF_CTRL0);
        chk("rst_ctrl", v, 16'h0000); // state cleared
        $display("reset done");
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        t_idle();
        t_pen_interrupt_mode();
        t_conv(1'b1, 5'h1f, 4'h1);
        t_conv(1'b0, 5'h03, 4'h0);
        t_auto();
        t_pen_trigger_mode();
        t_aux();
        t_reset();
        close_out();
    end
endmodule
`default_nettype wire
